// file: core/dmae_chan.sv
// dmae_chan: one channel's counters and interrupt decision
`timescale 1ns/100ps
module dmae_chan (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  // register writes
  input  wire logic        i_wr_ctr,
  input  wire logic        i_wr_sfc,
  input  wire logic        i_wr_mcr,
  input  wire logic [15:0] i_wdata,
  // one element read finished
  input  wire logic        i_done,
  // state
  output logic [15:0]      o_ctr,
  output logic [15:0]      o_sfc,
  output logic [15:0]      o_mcr,
  output logic             o_irq,
  output logic             o_blk_end
);
  logic [15:0] reload, next_reload;
  logic [15:0] next_ctr, next_sfc, next_mcr;
  logic        last_elem, half, last_frm;

  always_comb
  begin
    next_ctr = o_ctr;
    next_sfc = o_sfc;
    next_mcr = o_mcr;
    next_reload = reload;
    last_elem = (o_ctr == 16'h0000);
    half = (o_ctr == (reload >> 1));
    last_frm = (o_sfc[dmae_pkg::FRM_W-1:0] == 8'h00);
    o_irq = 1'b0;
    o_blk_end = 1'b0;
    if (i_done)
    begin
      next_ctr = last_elem ? reload : o_ctr - 16'h0001;
      if (o_mcr[dmae_pkg::MCR_ABU])
        o_irq = last_elem || (o_mcr[dmae_pkg::MCR_IRQ_MODE_BIT] && half);
      else
      begin
        o_blk_end = last_elem && last_frm;
        if (last_elem && !last_frm)
          next_sfc[7:0] = o_sfc[7:0] - 8'h01;
        o_irq = o_mcr[dmae_pkg::MCR_IRQ_MODE_BIT] ? last_elem : o_blk_end;
      end
      // no interrupt without the enable bit
      o_irq = o_irq && o_mcr[dmae_pkg::MCR_IRQ_ENABLE_BIT];
    end
    // a software write wins over the hardware update
    if (i_wr_ctr)
    begin
      next_ctr = i_wdata;
      next_reload = i_wdata;
    end
    if (i_wr_sfc)
      next_sfc = i_wdata;
    if (i_wr_mcr)
      next_mcr = i_wdata;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      o_ctr <= dmae_pkg::REG_RST;
      o_sfc <= dmae_pkg::REG_RST;
      o_mcr <= dmae_pkg::REG_RST;
      reload <= dmae_pkg::REG_RST;
    end
    else
    begin
      o_ctr <= next_ctr;
      o_sfc <= next_sfc;
      o_mcr <= next_mcr;
      reload <= next_reload;
    end
  end
endmodule

// file: core/dmae_fifo.sv
// dmae_fifo: small synchronous fifo for pending element transfers
`timescale 1ns/100ps
module dmae_fifo #(
  parameter int W = 3,
  parameter int D = 8
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst_b,
  // fill side
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  // drain side
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic [W-1:0]      o_out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wr_ptr, next_wr_ptr;
  logic [AW-1:0] rd_ptr, next_rd_ptr;
  logic [AW:0]   fill, next_fill;
  logic          push, pop;

  always_comb
  begin
    push = i_in_valid && o_in_ready;
    pop = o_out_valid && i_out_ready;
    next_wr_ptr = push ? AW'((wr_ptr + 1'b1) % D) : wr_ptr;
    next_rd_ptr = pop ? AW'((rd_ptr + 1'b1) % D) : rd_ptr;
    next_fill = fill + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      fill <= next_fill;
    end
  end

  // storage needs no reset, fill guards every read
  always_ff @(posedge i_clk)
  begin
    if (push)
      mem[wr_ptr] <= i_in_data;
  end

  assign o_in_ready = (fill != (AW+1)'(D));
  assign o_out_valid = (fill != '0);
  assign o_out_data = mem[rd_ptr];
endmodule

// file: core/dmae_top.sv
// dmae_top: event pacing and interrupt routing of a six-channel dma
`timescale 1ns/100ps
// Behaviour
// - enable bit and mode bit pick interrupts; enable low means never interrupt
// - auto-buffer: full buffer only, or half and full when mode bit set
// - multi-frame, mode 0: interrupt only at block end, counts both zero
// - multi-frame, mode 1: interrupt at each frame end and block end
// - four-bit sync field picks pacing event; zero runs unsynchronised
// - codes 1,2,5,6: serial port 0/1 receive and transmit; 3,4 reserved
// - codes d,e,f: timer 0, external interrupt 3, timer 1; rest reserved
// - each of six channels has its own interrupt; 0 to 3 shared
// - channels 2 and 3 share lines 10 and 11 with serial 1
// - channel 1 shares line 7 with timer 1; channel 0 line 6
// - reset: route field 00, lines carry timer 1 and serial 1
// - route 01: lines 10 and 11 carry channels 2 and 3
// - route 10: lines 6,7,10,11 carry channels 0-3; 11 reserved
// - priority and enable register sits at address 54h
// - pointer at 55h; plain data port 57h leaves pointer unchanged
// - data port 56h reads and writes the selected register
// - each access at 56h advances the pointer by one afterwards
// - element counter decrements after each element read, and reloads after the read at zero
// - multi-frame: frame counter decrements on the last read of each frame except the final one
module dmae_top (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  // memory-mapped register port
  input  wire logic [6:0]  i_mmr_addr,
  input  wire logic        i_mmr_wr,
  input  wire logic        i_mmr_rd,
  input  wire logic [15:0] i_mmr_wdata,
  output logic [15:0]      o_mmr_rdata,
  // pacing events, one-cycle pulses
  input  wire logic        i_sp0_rx_evt,
  input  wire logic        i_sp0_tx_evt,
  input  wire logic        i_sp1_rx_evt,
  input  wire logic        i_sp1_tx_evt,
  input  wire logic        i_timer0_irq,
  input  wire logic        i_ext_irq3_b,
  // shared interrupt sources
  input  wire logic        i_timer1_irq,
  input  wire logic        i_serial1_rx_irq,
  input  wire logic        i_serial1_tx_irq,
  // element transfer requests
  output logic             o_xfer_valid,
  output logic [2:0]       o_xfer_chan,
  input  wire logic        i_xfer_ready,
  // cpu interrupt lines
  output logic             o_cpu_irq6,
  output logic             o_cpu_irq7,
  output logic             o_cpu_irq10,
  output logic             o_cpu_irq11,
  output logic             o_chan4_irq,
  output logic             o_chan5_irq
);
  localparam int NCH = dmae_pkg::NCH;

  // ----------------------------------------
  // functions
  // ----------------------------------------
  function automatic logic [5:0] sub_addr(input int ch, input logic [5:0] fld);
    sub_addr = 6'(ch * 5) + fld;
  endfunction

  function automatic logic sync_hit(input logic [3:0] syn, input logic [6:0] ev);
    unique case (syn)
      dmae_pkg::SYN_FREE: sync_hit = 1'b1;
      dmae_pkg::SYN_SP0_RX: sync_hit = ev[0];
      dmae_pkg::SYN_SP0_TX: sync_hit = ev[1];
      dmae_pkg::SYN_SP1_RX: sync_hit = ev[2];
      dmae_pkg::SYN_SP1_TX: sync_hit = ev[3];
      dmae_pkg::SYN_TIM0: sync_hit = ev[4];
      dmae_pkg::SYN_EXT3: sync_hit = ev[5];
      dmae_pkg::SYN_TIM1: sync_hit = ev[6];
      // reserved codes never pace a transfer
      default: sync_hit = 1'b0;
    endcase
  endfunction

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic [15:0] prec, next_prec;
  logic [5:0]  ptr, next_ptr;
  logic [15:0] next_rdata;
  logic        sub_acc, auto_acc;
  logic [15:0] sub_rd;
  logic [NCH-1:0] wr_ctr, wr_sfc, wr_mcr;
  logic [15:0] ctr [NCH];
  logic [15:0] sfc [NCH];
  logic [15:0] mcr [NCH];
  logic [NCH-1:0] chan_irq, blk_end, done;
  logic [1:0]  ext_sync;
  logic        ext_prev;
  logic [6:0]  ev;
  logic [NCH-1:0] pend, next_pend, grant;
  logic        push_valid, push_ready;
  logic [2:0]  push_chan;
  logic [1:0]  sel;
  logic        next_irq6, next_irq7, next_irq10, next_irq11;

  // ----------------------------------------
  // pin synchroniser for external interrupt 3
  // ----------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      ext_sync <= 2'h3;
      ext_prev <= 1'b1;
    end
    else
    begin
      ext_sync <= {ext_sync[0], i_ext_irq3_b};
      ext_prev <= ext_sync[1];
    end
  end

  // falling edge of the active-low pin is the event
  assign ev = {i_timer1_irq, ext_prev && !ext_sync[1], i_timer0_irq,
               i_sp1_tx_evt, i_sp1_rx_evt, i_sp0_tx_evt, i_sp0_rx_evt};

  // ----------------------------------------
  // register port
  // ----------------------------------------
  always_comb
  begin
    sub_acc = (i_mmr_addr == dmae_pkg::ADR_AUTO) || (i_mmr_addr == dmae_pkg::ADR_PLAIN);
    auto_acc = (i_mmr_addr == dmae_pkg::ADR_AUTO) && (i_mmr_wr || i_mmr_rd);
    sub_rd = 16'h0000;
    for (int c = 0; c < NCH; c++)
    begin
      wr_ctr[c] = i_mmr_wr && sub_acc && (ptr == sub_addr(c, dmae_pkg::SUB_CTR));
      wr_sfc[c] = i_mmr_wr && sub_acc && (ptr == sub_addr(c, dmae_pkg::SUB_SFC));
      wr_mcr[c] = i_mmr_wr && sub_acc && (ptr == sub_addr(c, dmae_pkg::SUB_MCR));
      if (ptr == sub_addr(c, dmae_pkg::SUB_CTR))
        sub_rd = ctr[c];
      if (ptr == sub_addr(c, dmae_pkg::SUB_SFC))
        sub_rd = sfc[c];
      if (ptr == sub_addr(c, dmae_pkg::SUB_MCR))
        sub_rd = mcr[c];
    end
    next_ptr = ptr;
    if (i_mmr_wr && (i_mmr_addr == dmae_pkg::ADR_PTR))
      next_ptr = i_mmr_wdata[5:0];
    else if (auto_acc)
      next_ptr = ptr + 6'h01;
    next_prec = prec;
    // a finished block drops its enable bit
    next_prec[NCH-1:0] = prec[NCH-1:0] & ~blk_end;
    if (i_mmr_wr && (i_mmr_addr == dmae_pkg::ADR_PREC))
      next_prec = i_mmr_wdata;
    next_rdata = o_mmr_rdata;
    if (i_mmr_rd)
    begin
      unique case (1'b1)
        i_mmr_addr == dmae_pkg::ADR_PREC: next_rdata = prec;
        i_mmr_addr == dmae_pkg::ADR_PTR: next_rdata = {10'h000, ptr};
        sub_acc: next_rdata = sub_rd;
        default: next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      prec <= dmae_pkg::REG_RST;
      ptr <= dmae_pkg::PTR_RST;
      o_mmr_rdata <= dmae_pkg::REG_RST;
    end
    else
    begin
      prec <= next_prec;
      ptr <= next_ptr;
      o_mmr_rdata <= next_rdata;
    end
  end

  // ----------------------------------------
  // channels
  // ----------------------------------------
  for (genvar c = 0; c < NCH; c++)
  begin : g_chan
    dmae_chan u_chan (
      .i_clk     (i_clk),
      .i_rst_b   (i_rst_b),
      .i_wr_ctr  (wr_ctr[c]),
      .i_wr_sfc  (wr_sfc[c]),
      .i_wr_mcr  (wr_mcr[c]),
      .i_wdata   (i_mmr_wdata),
      .i_done    (done[c]),
      .o_ctr     (ctr[c]),
      .o_sfc     (sfc[c]),
      .o_mcr     (mcr[c]),
      .o_irq     (chan_irq[c]),
      .o_blk_end (blk_end[c])
    );
  end

  // ----------------------------------------
  // event credits and transfer queue
  // ----------------------------------------
  // one credit per channel: events landing while a credit waits are merged
  always_comb
  begin
    grant = '0;
    push_chan = 3'h0;
    push_valid = 1'b0;
    for (int c = NCH - 1; c >= 0; c--)
    begin
      if (pend[c])
      begin
        push_valid = 1'b1;
        push_chan = 3'(c);
      end
    end
    if (push_valid && push_ready)
      grant[push_chan] = 1'b1;
    for (int c = 0; c < NCH; c++)
    begin
      // an event in the grant cycle is kept, set wins
      next_pend[c] = (pend[c] && !grant[c])
                     || (prec[c] && sync_hit(sfc[c][15:12], ev));
      if (!prec[c])
        next_pend[c] = 1'b0;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
      pend <= '0;
    else
      pend <= next_pend;
  end

  dmae_fifo #(
    .W (3),
    .D (dmae_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_rst_b     (i_rst_b),
    .i_in_valid  (push_valid),
    .o_in_ready  (push_ready),
    .i_in_data   (push_chan),
    .o_out_valid (o_xfer_valid),
    .i_out_ready (i_xfer_ready),
    .o_out_data  (o_xfer_chan)
  );

  always_comb
  begin
    done = '0;
    if (o_xfer_valid && i_xfer_ready && (o_xfer_chan < 3'(NCH)))
      done[o_xfer_chan] = 1'b1;
  end

  // ----------------------------------------
  // interrupt routing
  // ----------------------------------------
  // the reserved route code behaves as the reset code
  always_comb
  begin
    sel = prec[dmae_pkg::PREC_SEL_LSB +: 2];
    next_irq6 = 1'b0;
    next_irq7 = i_timer1_irq;
    next_irq10 = i_serial1_rx_irq;
    next_irq11 = i_serial1_tx_irq;
    if (sel == dmae_pkg::SEL_C23 || sel == dmae_pkg::SEL_ALL)
    begin
      next_irq10 = chan_irq[2];
      next_irq11 = chan_irq[3];
    end
    if (sel == dmae_pkg::SEL_ALL)
    begin
      next_irq6 = chan_irq[0];
      next_irq7 = chan_irq[1];
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      o_cpu_irq6 <= 1'b0;
      o_cpu_irq7 <= 1'b0;
      o_cpu_irq10 <= 1'b0;
      o_cpu_irq11 <= 1'b0;
      o_chan4_irq <= 1'b0;
      o_chan5_irq <= 1'b0;
    end
    else
    begin
      o_cpu_irq6 <= next_irq6;
      o_cpu_irq7 <= next_irq7;
      o_cpu_irq10 <= next_irq10;
      o_cpu_irq11 <= next_irq11;
      o_chan4_irq <= chan_irq[4];
      o_chan5_irq <= chan_irq[5];
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  sequence s_auto_acc;
    (i_mmr_addr == dmae_pkg::ADR_AUTO) && (i_mmr_wr || i_mmr_rd);
  endsequence

  sequence s_plain_acc;
    (i_mmr_addr == dmae_pkg::ADR_PLAIN) && (i_mmr_wr || i_mmr_rd);
  endsequence

  a_ptr_autoinc: assert property (s_auto_acc |=> ptr == $past(ptr) + 6'h01)
    else $error("pointer did not advance after autoincrement access");

  a_ptr_plain_hold: assert property (s_plain_acc |=> ptr == $past(ptr))
    else $error("pointer moved on plain data access");

  a_prec_write: assert property (i_mmr_wr && i_mmr_addr == 7'h54 |=> prec == $past(i_mmr_wdata))
    else $error("priority register did not take the write");

  a_route_reset: assert property (sel == 2'h0 |=> o_cpu_irq10 == $past(i_serial1_rx_irq)
    && o_cpu_irq7 == $past(i_timer1_irq) && !o_cpu_irq6)
    else $error("reset routing wrong");

  a_route_c23: assert property (sel == 2'h1 |=> o_cpu_irq11 == $past(chan_irq[3])
    && o_cpu_irq7 == $past(i_timer1_irq))
    else $error("channel 2/3 routing wrong");

  a_route_all: assert property (sel == 2'h2 |=> o_cpu_irq6 == $past(chan_irq[0])
    && o_cpu_irq7 == $past(chan_irq[1]))
    else $error("full channel routing wrong");

  a_irq_needs_enable: assert property (!mcr[4][MCR_IRQ_ENABLE_BIT_C] |=> !o_chan4_irq)
    else $error("channel 4 interrupt with enable low");

  a_irq_one_pulse: assert property (o_chan5_irq |=> !o_chan5_irq)
    else $error("channel interrupt longer than one cycle");

  a_elem_decrement: assert property (done[0] && ctr[0] != 16'h0000 && !wr_ctr[0]
    |=> ctr[0] == $past(ctr[0]) - 16'h0001)
    else $error("element counter did not decrement");

  a_disabled_no_credit: assert property (!prec[1] |=> !pend[1])
    else $error("disabled channel holds a transfer credit");

  localparam int MCR_IRQ_ENABLE_BIT_C = dmae_pkg::MCR_IRQ_ENABLE_BIT;
endmodule

// file: inc/dmae_pkg.sv
// dmae_pkg: constants of the dma event and interrupt block
package dmae_pkg;
  localparam int NCH = 6;
  localparam int DW = 16;
  localparam int PW = 6;
  localparam int FRM_W = 8;
  localparam int SYN_W = 4;
  localparam int FIFO_DEPTH = 8;
  // ----------------------------------------
  // data-space addresses
  // ----------------------------------------
  localparam logic [6:0] ADR_PREC = 7'h54;
  localparam logic [6:0] ADR_PTR = 7'h55;
  localparam logic [6:0] ADR_AUTO = 7'h56;
  localparam logic [6:0] ADR_PLAIN = 7'h57;
  // ----------------------------------------
  // subbank layout, five words per channel
  // ----------------------------------------
  localparam logic [5:0] SUB_STRIDE = 6'h05;
  localparam logic [5:0] SUB_CTR = 6'h02;
  localparam logic [5:0] SUB_SFC = 6'h03;
  localparam logic [5:0] SUB_MCR = 6'h04;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int MCR_IRQ_ENABLE_BIT = 14;
  localparam int MCR_IRQ_MODE_BIT = 13;
  localparam int MCR_ABU = 12;
  localparam int SFC_SYN_LSB = 12;
  localparam int PREC_SEL_LSB = 6;
  // ----------------------------------------
  // codes and reset values
  // ----------------------------------------
  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [1:0] SEL_C23 = 2'h1;
  localparam logic [1:0] SEL_ALL = 2'h2;
  localparam logic [3:0] SYN_FREE = 4'h0;
  localparam logic [3:0] SYN_SP0_RX = 4'h1;
  localparam logic [3:0] SYN_SP0_TX = 4'h2;
  localparam logic [3:0] SYN_SP1_RX = 4'h5;
  localparam logic [3:0] SYN_SP1_TX = 4'h6;
  localparam logic [3:0] SYN_TIM0 = 4'hd;
  localparam logic [3:0] SYN_EXT3 = 4'he;
  localparam logic [3:0] SYN_TIM1 = 4'hf;
  localparam logic [15:0] REG_RST = 16'h0000;
  localparam logic [5:0] PTR_RST = 6'h00;
endpackage

// file: tb/dmae_partner.sv
// dmae_partner: transfer consumer at the far side of the dma block
`timescale 1ns/100ps
module dmae_partner (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  // consumer pacing
  input  wire logic       i_stall,
  input  wire logic       i_slow,
  // transfer link
  input  wire logic       i_xfer_valid,
  input  wire logic [2:0] i_xfer_chan,
  output logic            o_xfer_ready,
  // bookkeeping
  output logic [15:0]     o_taken,
  output logic [2:0]      o_last_chan
);
  logic phase;

  initial
  begin
    o_xfer_ready = 1'b0;
    phase = 1'b0;
  end

  // ready moves on the falling edge only, clear of the sampling edge
  always @(negedge i_clk)
  begin
    phase <= ~phase;
    o_xfer_ready <= i_rst_b && !i_stall && (!i_slow || phase);
  end

  // one element read per cycle with valid and ready high
  always @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      o_taken <= 16'h0000;
      o_last_chan <= 3'h0;
    end
    else if (i_xfer_valid && o_xfer_ready)
    begin
      o_taken <= o_taken + 16'h0001;
      o_last_chan <= i_xfer_chan;
    end
  end
endmodule

// file: tb/dmae_top_test.sv
// dmae_top_test: self-checking bench of the dma event and interrupt block
`timescale 1ns/100ps
module dmae_top_test;
  // ----------------------------------------
  // harness
  // ----------------------------------------
  logic        i_clk, i_rst_b, i_mmr_wr, i_mmr_rd;
  logic [6:0]  i_mmr_addr, evt;
  logic [15:0] i_mmr_wdata, o_mmr_rdata, taken, base;
  logic        i_serial1_rx_irq, i_serial1_tx_irq, o_xfer_valid, i_xfer_ready;
  logic [2:0]  o_xfer_chan, last_chan, mon_ch;
  logic        o_cpu_irq6, o_cpu_irq7, o_cpu_irq10, o_cpu_irq11, o_chan4_irq, o_chan5_irq;
  logic        stall, slow, mon_on;
  logic [3:0]  mask;
  logic [5:0]  lines;
  int          fail_count = 0;
  int          comparisons = 0;
  int          cycles = 0;

  assign lines = {o_chan5_irq, o_chan4_irq, o_cpu_irq11, o_cpu_irq10, o_cpu_irq7, o_cpu_irq6};

  dmae_top u_dut (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_mmr_addr(i_mmr_addr), .i_mmr_wr(i_mmr_wr),
    .i_mmr_rd(i_mmr_rd), .i_mmr_wdata(i_mmr_wdata), .o_mmr_rdata(o_mmr_rdata),
    .i_sp0_rx_evt(evt[0]), .i_sp0_tx_evt(evt[1]), .i_sp1_rx_evt(evt[2]),
    .i_sp1_tx_evt(evt[3]), .i_timer0_irq(evt[4]), .i_ext_irq3_b(~evt[5]),
    .i_timer1_irq(evt[6]), .i_serial1_rx_irq(i_serial1_rx_irq),
    .i_serial1_tx_irq(i_serial1_tx_irq), .o_xfer_valid(o_xfer_valid),
    .o_xfer_chan(o_xfer_chan), .i_xfer_ready(i_xfer_ready), .o_cpu_irq6(o_cpu_irq6),
    .o_cpu_irq7(o_cpu_irq7), .o_cpu_irq10(o_cpu_irq10), .o_cpu_irq11(o_cpu_irq11),
    .o_chan4_irq(o_chan4_irq), .o_chan5_irq(o_chan5_irq));

  dmae_partner u_far (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_stall(stall), .i_slow(slow),
    .i_xfer_valid(o_xfer_valid), .i_xfer_chan(o_xfer_chan), .o_xfer_ready(i_xfer_ready),
    .o_taken(taken), .o_last_chan(last_chan));

  initial
  begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  // a hang anywhere ends in the closing report
  always @(posedge i_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fail_count = fail_count + 1;
      test_done();
    end
  end

  // irq pulse lands one cycle after the done that caused it
  always @(posedge i_clk)
    if (mon_on && lines[mon_ch] === 1'b1 && taken > base && taken - base <= 16'h0004)
      mask[2'(taken - base - 16'h0001)] <= 1'b1;

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic test_done();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] want);
    comparisons++;
    if (seen !== want)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, want, seen);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(negedge i_clk);
    i_mmr_addr = a;
    i_mmr_wdata = d;
    i_mmr_wr = 1'b1;
    @(negedge i_clk);
    i_mmr_wr = 1'b0;
  endtask

  task automatic rdchk(input string name, input logic [6:0] a, input logic [15:0] want);
    @(negedge i_clk);
    i_mmr_addr = a;
    i_mmr_rd = 1'b1;
    @(negedge i_clk);
    i_mmr_rd = 1'b0;
    chk(name, o_mmr_rdata, want);
  endtask

  task automatic pulse(input logic [6:0] e, input int gap);
    @(negedge i_clk);
    evt = e;
    @(negedge i_clk);
    evt = 7'h00;
    repeat (gap) @(negedge i_clk);
  endtask

  // element count, sync/frame and mode words through the autoincrement port
  task automatic chan_setup(input int ch, input logic [15:0] c, s, m);
    wr(dmae_pkg::ADR_PTR, 16'(ch * 5 + 2));
    wr(dmae_pkg::ADR_AUTO, c);
    wr(dmae_pkg::ADR_AUTO, s);
    wr(dmae_pkg::ADR_AUTO, m);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    rdchk("prec_rst", dmae_pkg::ADR_PREC, 16'h0000);
    rdchk("ptr_rst", dmae_pkg::ADR_PTR, 16'h0000);
    wr(dmae_pkg::ADR_PTR, 16'h0007);
    wr(dmae_pkg::ADR_AUTO, 16'h1234);
    rdchk("ptr_inc", dmae_pkg::ADR_PTR, 16'h0008);
    wr(dmae_pkg::ADR_PLAIN, 16'hd003);
    rdchk("ptr_keep", dmae_pkg::ADR_PTR, 16'h0008);
    wr(dmae_pkg::ADR_PTR, 16'h0007);
    rdchk("ctr_auto", dmae_pkg::ADR_AUTO, 16'h1234);
    rdchk("sfc_plain", dmae_pkg::ADR_PLAIN, 16'hd003);
    rdchk("ptr_read", dmae_pkg::ADR_PTR, 16'h0008);
    wr(dmae_pkg::ADR_PREC, 16'h0080);
    rdchk("prec", dmae_pkg::ADR_PREC, 16'h0080);
    wr(7'h53, 16'hffff);
    rdchk("unmapped", 7'h53, 16'h0000);
    wr(dmae_pkg::ADR_PREC, 16'h0000);
  endtask

  task automatic t_share();
    logic [1:0] rt;
    for (int r = 0; r < 3; r++)
    begin
      rt = 2'(r);
      wr(dmae_pkg::ADR_PREC, {8'h00, rt, 6'h00});
      @(negedge i_clk);
      evt[6] = 1'b1;
      i_serial1_rx_irq = 1'b1;
      i_serial1_tx_irq = 1'b1;
      @(negedge i_clk);
      evt[6] = 1'b0;
      i_serial1_rx_irq = 1'b0;
      i_serial1_tx_irq = 1'b0;
      chk("share", {12'h000, lines[3:0]}, {12'h000, rt == 2'h0, rt == 2'h0, rt != 2'h2, 1'b0});
      @(negedge i_clk);
      chk("share_end", {12'h000, lines[3:0]}, 16'h0000);
    end
  endtask

  task automatic t_sync();
    logic [3:0] codes [7] = '{4'h1, 4'h2, 4'h5, 4'h6, 4'hd, 4'he, 4'hf};
    logic [3:0] code;
    for (int i = 0; i < 9; i++)
    begin
      code = (i < 7) ? codes[i] : ((i == 7) ? 4'h3 : 4'h1);
      chan_setup(1, 16'h00ff, {code, 12'h000}, 16'h0000);
      wr(dmae_pkg::ADR_PREC, (i == 8) ? 16'h0000 : 16'h0002);
      base = taken;
      pulse(7'h7f & ~(7'h01 << i), 8);
      chk("sync_other", taken - base, 16'h0000);
      pulse(7'h01 << (i % 7), 8);
      chk("sync_own", taken - base, (i < 7) ? 16'h0001 : 16'h0000);
      wr(dmae_pkg::ADR_PREC, 16'h0000);
    end
  endtask

  // free-running channel against a stalled consumer fills the fifo
  task automatic t_fifo();
    chan_setup(3, 16'h00ff, 16'h0000, 16'h0000);
    stall = 1'b1;
    base = taken;
    wr(dmae_pkg::ADR_PREC, 16'h0008);
    repeat (20) @(negedge i_clk);
    wr(dmae_pkg::ADR_PREC, 16'h0000);
    chk("fifo_full", {15'h0000, o_xfer_valid}, 16'h0001);
    slow = 1'b1;
    stall = 1'b0;
    repeat (40) @(negedge i_clk);
    chk("fifo_fill", {15'h0000, taken - base inside {16'h0008, 16'h0009}}, 16'h0001);
    chk("fifo_empty", {15'h0000, o_xfer_valid}, 16'h0000);
    chk("fifo_chan", {13'h0000, last_chan}, 16'h0003);
    slow = 1'b0;
  endtask

  task automatic t_irq();
    logic [15:0] mcr [5] = '{16'h4000, 16'h6000, 16'h5000, 16'h7000, 16'h2000};
    logic [7:0]  frm [5] = '{8'h01, 8'h01, 8'h00, 8'h00, 8'h01};
    logic [15:0] ctr [5] = '{16'h0001, 16'h0001, 16'h0003, 16'h0003, 16'h0001};
    logic [3:0]  want [5] = '{4'h8, 4'ha, 4'h8, 4'hc, 4'h0};
    for (int i = 0; i < 6; i++)
    begin
      chan_setup(i, ctr[i % 5], {8'h10, frm[i % 5]}, mcr[i % 5]);
      wr(dmae_pkg::ADR_PREC, 16'h0080 | (16'h0001 << i));
      mon_ch = 3'(i);
      base = taken;
      mask = 4'h0;
      mon_on = 1'b1;
      for (int k = 1; k <= 4; k++)
      begin
        pulse(7'h01, 0);
        for (int w = 0; w < 20 && taken - base < 16'(k); w++)
          @(negedge i_clk);
        repeat (2) @(negedge i_clk);
      end
      mon_on = 1'b0;
      wr(dmae_pkg::ADR_PREC, 16'h0000);
      chk("irq_mask", {12'h000, mask}, {12'h000, want[i % 5]});
    end
  endtask

  // ----------------------------------------
  // main
  // ----------------------------------------
  initial
  begin
    i_rst_b = 1'b0;
    i_mmr_addr = 7'h00;
    i_mmr_wr = 1'b0;
    i_mmr_rd = 1'b0;
    i_mmr_wdata = 16'h0000;
    evt = 7'h00;
    i_serial1_rx_irq = 1'b0;
    i_serial1_tx_irq = 1'b0;
    stall = 1'b0;
    slow = 1'b0;
    mon_on = 1'b0;
    mon_ch = 3'h0;
    mask = 4'h0;
    base = 16'h0000;
    repeat (12) @(negedge i_clk);
    i_rst_b = 1'b1;
    t_regs();
    t_share();
    t_sync();
    t_fifo();
    t_irq();
    test_done();
  end
endmodule
